// [hdl/instr_abort_syndrome.sv]
// Purpose: Encode fetch abort reports into the low syndrome bits, with a register view.
// Assumes: Fault reports come from logic on the same clock, one cycle per report.
// Notes: A report that cannot be encoded in this configuration is dropped and flagged.
`timescale 1ns/1ps
`default_nettype none

module instr_abort_syndrome
	import abort_syn_pkg::*;
#(
	parameter bit LARGE_ADDR_FEATURE = 1'b1,
	parameter bit RELIABILITY_FEATURE = 1'b0,
	parameter bit REALM_FEATURE = 1'b1,
	parameter bit HW_ACCESS_DIRTY_FEATURE = 1'b1
)
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire fault_t fault_in,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output syndrome_t syndrome,
	output logic abort_taken,
	output logic irq
);

	typedef struct packed {
		syndrome_t syn;
		logic [EV_W-1:0] stat;
		logic [EV_W-1:0] mask;
		logic en;
		logic ack;
		logic [31:0] rdata;
		logic taken;
	} state_t;

	state_t q;
	state_t d;
	logic [6:0] enc;
	logic req;

	// Returns {encodable, code}; the partner supplies the stage 2 level on walks.
	function automatic logic [6:0] encode(input fault_t f);
		logic ok;
		logic [5:0] c;
		logic std;
		logic m1;
		ok = 1'b0;
		c = FFC_TLB;
		std = (f.level <= LVL_MAX);
		m1 = (f.level == LVL_M1);
		case (f.kind)
			FK_ADDR:
			begin
				ok = std | (m1 & LARGE_ADDR_FEATURE);
				c = m1 ? FFC_ASF_M1 : {FFC_ASF_L0[5:2], f.level[1:0]};
			end
			FK_TRANS:
			begin
				ok = std | (m1 & LARGE_ADDR_FEATURE);
				c = m1 ? FFC_TF_M1 : {FFC_TF_L0[5:2], f.level[1:0]};
			end
			FK_AFLAG:
			begin
				ok = std & ((f.level != 3'h0) | LARGE_ADDR_FEATURE);
				c = {FFC_AFF_L0[5:2], f.level[1:0]};
			end
			FK_PERM:
			begin
				ok = std & ((f.level != 3'h0) | LARGE_ADDR_FEATURE);
				c = {FFC_PF_L0[5:2], f.level[1:0]};
			end
			FK_EXT:
			begin
				ok = 1'b1;
				c = FFC_EXT;
			end
			FK_EXT_WALK:
			begin
				ok = std | (m1 & LARGE_ADDR_FEATURE);
				c = m1 ? FFC_EXTW_M1 : {FFC_EXTW_L0[5:2], f.level[1:0]};
			end
			FK_PAR:
			begin
				ok = !RELIABILITY_FEATURE;
				c = FFC_PAR;
			end
			FK_PAR_WALK:
			begin
				ok = !RELIABILITY_FEATURE & (std | (m1 & LARGE_ADDR_FEATURE));
				c = m1 ? FFC_PARW_M1 : {FFC_PARW_L0[5:2], f.level[1:0]};
			end
			FK_GPF_WALK:
			begin
				ok = REALM_FEATURE & (std | (m1 & LARGE_ADDR_FEATURE));
				c = m1 ? FFC_GPFW_M1 : {FFC_GPFW_L0[5:2], f.level[1:0]};
			end
			FK_GPF:
			begin
				ok = REALM_FEATURE;
				c = FFC_GPF;
			end
			FK_TLB:
			begin
				ok = 1'b1;
				c = FFC_TLB;
			end
			FK_ATOM:
			begin
				ok = HW_ACCESS_DIRTY_FEATURE;
				c = FFC_ATOM;
			end
			default:
			begin
				ok = 1'b0;
				c = FFC_TLB;
			end
		endcase
		return {ok, c};
	endfunction : encode

	// True when a code belongs to the defined set of this configuration.
	function automatic logic code_defined(input logic [5:0] c);
		logic r;
		r = 1'b0;
		if (c[5:3] == 3'h0)
		begin
			r = 1'b1;
		end
		else if (c[5:2] == FFC_AFF_L0[5:2] || c[5:2] == FFC_PF_L0[5:2])
		begin
			r = (c[1:0] != 2'h0) | LARGE_ADDR_FEATURE;
		end
		else if (c == FFC_EXT || c == FFC_TLB || c[5:2] == FFC_EXTW_L0[5:2])
		begin
			r = 1'b1;
		end
		else if (c == FFC_EXTW_M1 || c == FFC_ASF_M1 || c == FFC_TF_M1)
		begin
			r = LARGE_ADDR_FEATURE;
		end
		else if (c == FFC_PAR || c[5:2] == FFC_PARW_L0[5:2])
		begin
			r = !RELIABILITY_FEATURE;
		end
		else if (c == FFC_PARW_M1)
		begin
			r = !RELIABILITY_FEATURE & LARGE_ADDR_FEATURE;
		end
		else if (c == FFC_GPF || c[5:2] == FFC_GPFW_L0[5:2])
		begin
			r = REALM_FEATURE;
		end
		else if (c == FFC_GPFW_M1)
		begin
			r = REALM_FEATURE & LARGE_ADDR_FEATURE;
		end
		else if (c == FFC_ATOM)
		begin
			r = HW_ACCESS_DIRTY_FEATURE;
		end
		else
		begin
			r = 1'b0;
		end
		return r;
	endfunction : code_defined

	// Read multiplexer; unmapped words read as zero.
	function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a, input state_t s);
		logic [31:0] v;
		v = 32'h0;
		if (a == REG_SYN)
		begin
			v[SYN_W-1:0] = s.syn;
		end
		else if (a == REG_STAT)
		begin
			v[EV_W-1:0] = s.stat;
		end
		else if (a == REG_MASK)
		begin
			v[EV_W-1:0] = s.mask;
		end
		else if (a == REG_CTRL)
		begin
			v[CTRL_EN] = s.en;
		end
		return v;
	endfunction : reg_read

	assign enc = encode(fault_in);
	assign req = (read | write) & ~q.ack;

	always_comb
	begin
		d = q;
		d.ack = 1'b0;
		d.taken = 1'b0;
		// Every request waits exactly one cycle so read data can come from a flop.
		if (req)
		begin
			d.ack = 1'b1;
			d.rdata = reg_read(address, q);
		end
		if (q.ack & write)
		begin
			if (address == REG_MASK)
			begin
				d.mask = writedata[EV_W-1:0];
			end
			else if (address == REG_CTRL)
			begin
				d.en = writedata[CTRL_EN];
			end
		end
		// Only bits the reader actually saw are cleared, so a late event survives.
		if (q.ack & read & (address == REG_STAT))
		begin
			d.stat = q.stat & ~q.rdata[EV_W-1:0];
		end
		if (fault_in.valid & q.en)
		begin
			if (enc[6])
			begin
				d.syn.rsv8 = 1'b0;
				d.syn.rsv6 = 1'b0;
				d.syn.stage1_walk_flag = fault_in.stage2 & fault_in.s1_walk;
				d.syn.fetch_fault_code = enc[5:0];
				d.stat[EV_REC] = 1'b1;
				d.taken = 1'b1;
			end
			else
			begin
				d.stat[EV_BAD] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			// Zeroed for a clean view, though software may not rely on it.
			q.syn <= '0;
			q.stat <= '0;
			q.mask <= MASK_RST;
			q.en <= CTRL_EN_RST;
			q.ack <= 1'b0;
			q.rdata <= 32'h0;
			q.taken <= 1'b0;
		end
		else
		begin
			q <= d;
		end
	end

	assign readdata = q.rdata;
	assign waitrequest = req;
	assign syndrome = q.syn;
	assign abort_taken = q.taken;
	assign irq = |(q.stat & q.mask);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_req;
		(read | write) && waitrequest;
	endsequence

	sequence s_done;
		!waitrequest;
	endsequence

	sequence s_walk_fault;
		fault_in.valid && q.en && enc[6] && fault_in.stage2 && fault_in.s1_walk;
	endsequence

	bus_answer_a: assert property (s_req |=> s_done)
		else $error("bus request not answered in one cycle");
	walk_set_a: assert property (s_walk_fault |=> abort_taken && syndrome.stage1_walk_flag)
		else $error("walk flag not set for stage 2 walk fault");
	walk_zero_a: assert property (abort_taken && !$past(fault_in.stage2) |-> !syndrome.stage1_walk_flag)
		else $error("walk flag set without stage 2 fault");
	reserved_bits_a: assert property (!syndrome.rsv8 && !syndrome.rsv6)
		else $error("reserved syndrome bit set");
	code_legal_a: assert property (abort_taken |-> code_defined(syndrome.fetch_fault_code))
		else $error("reserved fault code reported");
	trans_code_a: assert property (fault_in.valid && q.en && fault_in.kind == FK_TRANS
		&& fault_in.level <= LVL_MAX |=> syndrome.fetch_fault_code == {4'h1, $past(fault_in.level[1:0])})
		else $error("translation fault code wrong");
	ext_abort_a: assert property (fault_in.valid && q.en && fault_in.kind == FK_EXT
		|=> abort_taken && syndrome.fetch_fault_code == 6'h10)
		else $error("external abort code wrong");
	feature_gate_a: assert property (!HW_ACCESS_DIRTY_FEATURE |-> syndrome.fetch_fault_code != 6'h31)
		else $error("atomic update code without feature");
	rc_clear_a: assert property (q.ack && read && address == REG_STAT && !fault_in.valid
		|=> (q.stat & $past(q.rdata[EV_W-1:0])) == '0)
		else $error("status not cleared by read");
	irq_level_a: assert property (irq == |(q.stat & q.mask))
		else $error("interrupt does not follow masked status");

endmodule : instr_abort_syndrome
`default_nettype wire

// [hdl/abort_syn_pkg.sv]
// Purpose: Shared constants and types for the fetch abort syndrome encoder.
// Assumes: Avalon-MM word addressing, one 32-bit word per register.
// Notes: Fault codes are six bits; levels use a three-bit code with -1 as 3'h7.
package abort_syn_pkg;
	localparam int ADDR_W = 2;
	localparam logic [1:0] REG_SYN = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_MASK = 2'h2;
	localparam logic [1:0] REG_CTRL = 2'h3;
	localparam int EV_W = 2;
	localparam int EV_REC = 0;
	localparam int EV_BAD = 1;
	localparam int CTRL_EN = 0;
	localparam logic [EV_W-1:0] MASK_RST = 2'h0;
	localparam logic CTRL_EN_RST = 1'h1;
	localparam int SYN_W = 9;
	localparam logic [2:0] LVL_M1 = 3'h7;
	localparam logic [2:0] LVL_MAX = 3'h3;
	localparam logic [5:0] FFC_ASF_L0 = 6'h00;
	localparam logic [5:0] FFC_TF_L0 = 6'h04;
	localparam logic [5:0] FFC_AFF_L0 = 6'h08;
	localparam logic [5:0] FFC_PF_L0 = 6'h0c;
	localparam logic [5:0] FFC_EXT = 6'h10;
	localparam logic [5:0] FFC_EXTW_M1 = 6'h13;
	localparam logic [5:0] FFC_EXTW_L0 = 6'h14;
	localparam logic [5:0] FFC_PAR = 6'h18;
	localparam logic [5:0] FFC_PARW_M1 = 6'h1b;
	localparam logic [5:0] FFC_PARW_L0 = 6'h1c;
	localparam logic [5:0] FFC_GPFW_M1 = 6'h23;
	localparam logic [5:0] FFC_GPFW_L0 = 6'h24;
	localparam logic [5:0] FFC_GPF = 6'h28;
	localparam logic [5:0] FFC_ASF_M1 = 6'h29;
	localparam logic [5:0] FFC_TF_M1 = 6'h2b;
	localparam logic [5:0] FFC_TLB = 6'h30;
	localparam logic [5:0] FFC_ATOM = 6'h31;

	typedef enum logic [3:0] {
		FK_ADDR = 4'h0,
		FK_TRANS = 4'h1,
		FK_AFLAG = 4'h2,
		FK_PERM = 4'h3,
		FK_EXT = 4'h4,
		FK_EXT_WALK = 4'h5,
		FK_PAR = 4'h6,
		FK_PAR_WALK = 4'h7,
		FK_GPF_WALK = 4'h8,
		FK_GPF = 4'h9,
		FK_TLB = 4'ha,
		FK_ATOM = 4'hb
	} fault_kind_t;

	typedef struct packed {
		logic valid;
		fault_kind_t kind;
		logic [2:0] level;
		logic stage2;
		logic s1_walk;
	} fault_t;

	typedef struct packed {
		logic rsv8;
		logic stage1_walk_flag;
		logic rsv6;
		logic [5:0] fetch_fault_code;
	} syndrome_t;
endpackage : abort_syn_pkg

// [sim/fault_source.sv]
// Purpose: Behavioural fault source standing in for the translation unit.
// Assumes: Same clock as the encoder; one report per send.
// Notes: Fields are scrambled between reports so stale values are never trusted.
`timescale 1ns/1ps
`default_nettype none
module fault_source
	import abort_syn_pkg::*;
(
	input wire logic clock,
	output fault_t fault_out
);
	initial fault_out = '0;
	task automatic send(input fault_kind_t k, input logic [2:0] l, input logic s2, input logic w);
		fault_t f;
		f = '{valid: 1'b1, kind: k, level: l, stage2: s2, s1_walk: w};
		@(posedge clock);
		fault_out <= f;
		@(posedge clock);
		fault_out <= {1'b0, ~f[9:0]};
	endtask : send
endmodule : fault_source
`default_nettype wire

// [sim/instr_abort_syndrome_test.sv]
// Purpose: Self-checking bench for the fetch abort syndrome encoder.
// Assumes: Default feature parameters of the design.
// Notes: Register reads go through the Avalon task; faults through the source model.
`timescale 1ns/1ps
`default_nettype none
module instr_abort_syndrome_test;
	import abort_syn_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic waitrequest;
	syndrome_t syndrome;
	logic abort_taken;
	logic irq;
	fault_t fault_in;
	int miscompares = 0;
	int checks = 0;
	localparam logic [12:0] TB [20] = '{{4'h0, 3'h0, 6'h00}, {4'h0, 3'h3, 6'h03},
		{4'h0, 3'h7, 6'h29}, {4'h1, 3'h0, 6'h04}, {4'h1, 3'h7, 6'h2b}, {4'h2, 3'h0, 6'h08},
		{4'h2, 3'h3, 6'h0b}, {4'h3, 3'h0, 6'h0c}, {4'h3, 3'h1, 6'h0d}, {4'h4, 3'h0, 6'h10},
		{4'h5, 3'h7, 6'h13}, {4'h5, 3'h3, 6'h17}, {4'h6, 3'h0, 6'h18}, {4'h7, 3'h7, 6'h1b},
		{4'h7, 3'h0, 6'h1c}, {4'h8, 3'h7, 6'h23}, {4'h8, 3'h3, 6'h27}, {4'h9, 3'h0, 6'h28},
		{4'ha, 3'h0, 6'h30}, {4'hb, 3'h0, 6'h31}};
	always #12.5 clock = ~clock;
	fault_source i_fault_source (.clock(clock), .fault_out(fault_in));
	instr_abort_syndrome i_instr_abort_syndrome (.clock(clock), .sys_rst(sys_rst),
		.fault_in(fault_in), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.syndrome(syndrome), .abort_taken(abort_taken), .irq(irq));
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clock);
		read <= ~w;
		write <= w;
		address <= a;
		writedata <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clock);
			if (waitrequest === 1'b0)
				break;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n == 20)
		begin
			miscompares++;
			give_verdict();
		end
	endtask : bus
	task automatic rd(input logic [1:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp, what);
	endtask : rd
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		#1;
	endtask : wr
	task automatic fire(input logic [3:0] k, input logic [2:0] l, input logic s2,
		input logic w, input logic [8:0] syn, input logic tk);
		i_fault_source.send(fault_kind_t'(k), l, s2, w);
		#1;
		chk({23'h0, syndrome}, {23'h0, syn}, "syndrome");
		chk({31'h0, abort_taken}, {31'h0, tk}, "taken");
	endtask : fire
	task automatic t_reset();
		rd(REG_MASK, 32'h0, "mask");
		rd(REG_CTRL, 32'h1, "ctrl");
		rd(REG_SYN, 32'h0, "syn");
		rd(REG_STAT, 32'h0, "stat");
		chk({31'h0, irq}, 32'h0, "irq");
		$display("done reset");
	endtask : t_reset
	task automatic t_codes();
		for (int i = 0; i < 20; i++)
			fire(TB[i][12:9], TB[i][8:6], 1'b0, 1'b1, {3'h0, TB[i][5:0]}, 1'b1);
		$display("done codes");
	endtask : t_codes
	task automatic t_walk();
		fire(4'h1, 3'h2, 1'b1, 1'b1, 9'h086, 1'b1);
		rd(REG_SYN, 32'h86, "syn");
		fire(4'h1, 3'h2, 1'b1, 1'b0, 9'h006, 1'b1);
		$display("done walk");
	endtask : t_walk
	task automatic t_irq();
		chk({31'h0, irq}, 32'h0, "masked");
		wr(REG_MASK, 32'h3);
		chk({31'h0, irq}, 32'h1, "irq");
		rd(REG_STAT, 32'h1, "stat");
		#1;
		chk({31'h0, irq}, 32'h0, "cleared");
		fire(4'h2, 3'h5, 1'b0, 1'b0, 9'h006, 1'b0);
		chk({31'h0, irq}, 32'h1, "bad irq");
		wr(REG_STAT, 32'h3);
		rd(REG_STAT, 32'h2, "stat bad");
		rd(REG_STAT, 32'h0, "stat clr");
		$display("done irq");
	endtask : t_irq
	task automatic t_disable();
		wr(REG_CTRL, 32'h0);
		fire(4'ha, 3'h0, 1'b0, 1'b0, 9'h006, 1'b0);
		rd(REG_STAT, 32'h0, "off");
		wr(REG_CTRL, 32'h1);
		fire(4'ha, 3'h0, 1'b0, 1'b0, 9'h030, 1'b1);
		$display("done disable");
	endtask : t_disable
	initial
	begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_codes();
		t_walk();
		t_irq();
		t_disable();
		give_verdict();
	end
endmodule : instr_abort_syndrome_test
`default_nettype wire
